//--- hdl/adcpk_top.sv
// sample packetizer control: registers, input sequencing, calibration and packets
`timescale 1ns/1ns
`default_nettype none
`include "adcpk_defines.svh"

// Behaviour
// - each input register holds the upper 24 destination bits, reset zero
// - bit 0 enables the input, reset zero; bits 7:1 reserved read-only
// - dropped flag set by hardware, cleared by reading the general register
// - samples left aligned; width code 0 gives 8 bits; code 2 reserved
// - width code 1 sends 16-bit samples, low four bits zero, msb first
// - width code 3 sends 32-bit samples, low 20 bits zero, msb first
// - eight-bit field sets samples per packet before the packet ends
// - samples per packet zero keeps packet open until a register access
// - general bit 1 selects the internal 0.8V calibration reference
// - general bit 0 enables conversion; input registers then read-only
// - first six pulses after enabling calibrate and produce no packets
// - from the seventh pulse each sample goes to its destination
// - six-pulse calibration repeats on every zero-to-one enable transition
// - a sampling pulse rising edge while idle converts the next enabled input, 12 bits
// - eight input registers at word stride from zero, then general register
module adcpk_top
   import adcpk_pkg::*;
#(
   parameter int NUM_INPUTS = `ADCPK_NUM_INPUTS
)(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_reg_req,
   input  wire logic        i_reg_wr,
   input  wire logic [5:0]  i_reg_addr,
   input  wire logic [31:0] i_reg_wdata,
   output logic             o_reg_ack,
   output logic [31:0]      o_reg_rdata,
   input  wire logic        i_sample_pulse,
   output logic             o_conv_start,
   output logic [2:0]       o_conv_input,
   output logic             o_cal_ref_sel,
   input  wire logic        i_conv_done,
   input  wire logic [11:0] i_conv_result,
   output logic             o_tx_valid,
   output logic [7:0]       o_tx_data,
   output logic             o_tx_end,
   output logic [23:0]      o_tx_dest,
   input  wire logic        i_tx_ready
);

   // ======
   // helpers

   // left-align a 12-bit result into the word and give its byte count
   function automatic logic [34:0] align_sample(input logic [11:0] res, input logic [1:0] wid);
      logic [34:0] r;
      r = 35'h000000000;
      case (wid)
         `ADCPK_WID_8:  r = {res[11:4], 24'h000000, 3'h1};
         `ADCPK_WID_16: r = {res, 4'h0, 16'h0000, 3'h2};
         `ADCPK_WID_32: r = {res, 20'h00000, 3'h4};
         default:       r = 35'h000000000;
      endcase
      return r;
   endfunction

   // next enabled input after cur, wrapping; bit 3 flags that one was found
   function automatic logic [3:0] next_input(input adcpk_route_s rt [NUM_INPUTS],
                                             input logic [2:0] cur);
      logic [3:0] r;
      logic [2:0] k;
      r = 4'h0;
      for (int i = 1; i <= NUM_INPUTS; i++) begin
         k = 3'((int'(cur) + i) % NUM_INPUTS);
         if (rt[k].en && !r[3]) begin
            r = {1'b1, k};
         end
      end
      return r;
   endfunction

   // ======
   // reset release through two flops
   logic rst_meta_r;
   logic rst_n_r;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_r <= 1'b0;
         rst_n_r    <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r    <= rst_meta_r;
      end
   end

   // ======
   // register state
   adcpk_route_s route_r [NUM_INPUTS];
   logic [1:0]   wid_r;
   logic [7:0]   spp_r;
   logic         cal_r;
   logic         en_r;
   logic         drop_r;
   logic         drop_set;
   logic [3:0]   acc_idx;
   logic         acc_wr;
   logic         acc_rd_gen;
   logic         acc_wr_gen;

   assign acc_idx    = i_reg_addr[5:2];
   assign acc_wr     = i_reg_req && i_reg_wr;
   assign acc_rd_gen = i_reg_req && !i_reg_wr && (acc_idx == `ADCPK_IDX_GEN);
   assign acc_wr_gen = acc_wr && (acc_idx == `ADCPK_IDX_GEN);

   // input routing words; writes are ignored while conversion is enabled
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         for (int i = 0; i < NUM_INPUTS; i++) begin
            route_r[i].dest <= `ADCPK_RT_DEST_RST;
            route_r[i].en   <= `ADCPK_RT_EN_RST;
         end
      end else if (acc_wr && !en_r && (acc_idx < 4'(NUM_INPUTS))) begin
         route_r[acc_idx[2:0]].dest <= i_reg_wdata[`ADCPK_RT_DEST_MSB:`ADCPK_RT_DEST_LSB];
         route_r[acc_idx[2:0]].en   <= i_reg_wdata[`ADCPK_RT_EN_BIT];
      end
   end

   // general control fields
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         wid_r <= `ADCPK_GEN_WID_RST;
         spp_r <= `ADCPK_GEN_SPP_RST;
         cal_r <= `ADCPK_GEN_CAL_RST;
         en_r  <= `ADCPK_GEN_EN_RST;
      end else if (acc_wr_gen) begin
         wid_r <= i_reg_wdata[`ADCPK_GEN_WID_MSB:`ADCPK_GEN_WID_LSB];
         spp_r <= i_reg_wdata[`ADCPK_GEN_SPP_MSB:`ADCPK_GEN_SPP_LSB];
         cal_r <= i_reg_wdata[`ADCPK_GEN_CAL_BIT];
         en_r  <= i_reg_wdata[`ADCPK_GEN_EN_BIT];
      end
   end

   // dropped flag: a new drop in the read cycle survives the clear
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         drop_r <= `ADCPK_GEN_DROP_RST;
      end else begin
         drop_r <= drop_set || (drop_r && !acc_rd_gen);
      end
   end

   // read data and acknowledge one cycle after the request
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_reg_ack   <= 1'b0;
         o_reg_rdata <= 32'h00000000;
      end else begin
         o_reg_ack   <= i_reg_req;
         o_reg_rdata <= 32'h00000000;
         if (i_reg_req && !i_reg_wr) begin
            if (acc_idx < 4'(NUM_INPUTS)) begin
               o_reg_rdata <= {route_r[acc_idx[2:0]].dest, 7'h00, route_r[acc_idx[2:0]].en};
            end else if (acc_idx == `ADCPK_IDX_GEN) begin
               o_reg_rdata <= {7'h00, drop_r, 6'h00, wid_r, spp_r, 6'h00, cal_r, en_r};
            end
         end
      end
   end

   assign o_cal_ref_sel = cal_r;

   // ======
   // calibration pulse counting
   logic       en_prev_r;
   logic       pulse_prev_r;
   logic       pulse_rise;
   logic [2:0] cal_cnt_r;
   logic       calibrating;
   adcpk_seq_e seq_r;
   logic       take_pulse;

   assign pulse_rise  = i_sample_pulse && !pulse_prev_r;
   assign calibrating = (cal_cnt_r < `ADCPK_CAL_PULSES);
   assign take_pulse  = pulse_rise && en_r && (seq_r == ADCPK_SEQ_IDLE);

   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         en_prev_r    <= 1'b0;
         pulse_prev_r <= 1'b0;
      end else begin
         en_prev_r    <= en_r;
         pulse_prev_r <= i_sample_pulse;
      end
   end

   // every rising enable restarts the six-pulse calibration
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         cal_cnt_r <= 3'h0;
      end else if (en_r && !en_prev_r) begin
         cal_cnt_r <= 3'h0;
      end else if (take_pulse && calibrating) begin
         cal_cnt_r <= cal_cnt_r + 3'h1;
      end
   end

   // ======
   // conversion sequencer
   logic [2:0]    cur_r;
   logic          discard_r;
   logic [3:0]    nxt;
   logic          send_busy;
   logic          load;
   logic [34:0]   aligned;
   adcpk_sample_s smp;
   logic [7:0]    pkt_cnt_r;
   logic          open_r;
   logic          close_pend_r;
   logic          close;
   logic [23:0]   last_dest_r;

   assign nxt = next_input(route_r, cur_r);

   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         seq_r        <= ADCPK_SEQ_IDLE;
         cur_r        <= 3'h7;
         discard_r    <= 1'b0;
         o_conv_start <= 1'b0;
         o_conv_input <= 3'h0;
      end else begin
         o_conv_start <= 1'b0;
         case (seq_r)
            ADCPK_SEQ_IDLE: begin
               // after calibration, a pulse that finds no enabled input converts nothing
               if (take_pulse && (calibrating || nxt[3])) begin
                  o_conv_start <= 1'b1;
                  o_conv_input <= nxt[3] ? nxt[2:0] : cur_r;
                  cur_r        <= nxt[3] ? nxt[2:0] : cur_r;
                  discard_r    <= calibrating;
                  seq_r        <= ADCPK_SEQ_CONV;
               end
            end
            ADCPK_SEQ_CONV: begin
               // pulses arriving mid-conversion are lost on purpose
               if (i_conv_done) begin
                  seq_r <= ADCPK_SEQ_IDLE;
               end
            end
            default: begin
               seq_r <= ADCPK_SEQ_IDLE;
            end
         endcase
      end
   end

   // result path: calibration results and reserved width never leave
   assign aligned  = align_sample(i_conv_result, wid_r);
   assign load     = (seq_r == ADCPK_SEQ_CONV) && i_conv_done && !discard_r &&
                     (wid_r != `ADCPK_WID_RSV) && !send_busy;
   assign drop_set = (seq_r == ADCPK_SEQ_CONV) && i_conv_done && !discard_r &&
                     (wid_r != `ADCPK_WID_RSV) && send_busy;
   assign smp = '{data: aligned[34:3], nbytes: aligned[2:0], dest: route_r[cur_r].dest,
                  last: (spp_r != 8'h00) && (pkt_cnt_r + 8'h01 == spp_r)};
   assign close      = close_pend_r && !load && !send_busy;

   // ======
   // packet bookkeeping
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pkt_cnt_r   <= 8'h00;
         open_r      <= 1'b0;
         last_dest_r <= 24'h000000;
      end else if (load) begin
         pkt_cnt_r   <= smp.last ? 8'h00 : pkt_cnt_r + 8'h01;
         open_r      <= !smp.last;
         last_dest_r <= smp.dest;
      end else if (close) begin
         pkt_cnt_r <= 8'h00;
         open_r    <= 1'b0;
      end
   end

   // a register access ends an open packet; a new access wins over the clear
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         close_pend_r <= 1'b0;
      end else begin
         close_pend_r <= (i_reg_req && open_r) || (close_pend_r && !close && open_r);
      end
   end

   // ======
   // byte sender
   adcpk_sender u_sender (
      .i_clk        (i_clk),
      .i_rst_n      (rst_n_r),
      .i_load       (load),
      .i_sample     (smp),
      .i_close      (close),
      .i_close_dest (last_dest_r),
      .o_busy       (send_busy),
      .o_tx_valid   (o_tx_valid),
      .o_tx_data    (o_tx_data),
      .o_tx_end     (o_tx_end),
      .o_tx_dest    (o_tx_dest),
      .i_tx_ready   (i_tx_ready)
   );

endmodule
`default_nettype wire

//--- hdl/adcpk_defines.svh
// register offsets, field positions, reset values and counts for the sample packetizer
`ifndef ADCPK_DEFINES_SVH
`define ADCPK_DEFINES_SVH

// ======
// register map (byte offsets, 32-bit words)
`define ADCPK_NUM_INPUTS     8
`define ADCPK_OFF_INPUT6     6'h18
`define ADCPK_OFF_INPUT7     6'h1c
`define ADCPK_OFF_GEN        6'h20
`define ADCPK_IDX_GEN        4'h8

// ======
// per-input route register fields
`define ADCPK_RT_DEST_MSB    31
`define ADCPK_RT_DEST_LSB    8
`define ADCPK_RT_EN_BIT      0
`define ADCPK_RT_DEST_RST    24'h000000
`define ADCPK_RT_EN_RST      1'b0

// ======
// general control register fields
`define ADCPK_GEN_DROP_BIT   24
`define ADCPK_GEN_WID_MSB    17
`define ADCPK_GEN_WID_LSB    16
`define ADCPK_GEN_SPP_MSB    15
`define ADCPK_GEN_SPP_LSB    8
`define ADCPK_GEN_CAL_BIT    1
`define ADCPK_GEN_EN_BIT     0
`define ADCPK_GEN_DROP_RST   1'b1
`define ADCPK_GEN_WID_RST    2'h1
`define ADCPK_GEN_SPP_RST    8'h01
`define ADCPK_GEN_CAL_RST    1'b0
`define ADCPK_GEN_EN_RST     1'b0

// ======
// sample width codes and calibration count
`define ADCPK_WID_8          2'h0
`define ADCPK_WID_16         2'h1
`define ADCPK_WID_RSV        2'h2
`define ADCPK_WID_32         2'h3
`define ADCPK_CAL_PULSES     3'h6

`endif

//--- hdl/adcpk_pkg.sv
// types shared by the sample packetizer modules
package adcpk_pkg;

   // ======
   // per-input routing setting
   typedef struct packed {
      logic [23:0] dest;
      logic        en;
   } adcpk_route_s;

   // ======
   // one aligned sample handed to the byte sender
   typedef struct packed {
      logic [31:0] data;
      logic [2:0]  nbytes;
      logic        last;
      logic [23:0] dest;
   } adcpk_sample_s;

   typedef enum logic [1:0] {
      ADCPK_SEQ_IDLE,
      ADCPK_SEQ_CONV
   } adcpk_seq_e;

   typedef enum logic [1:0] {
      ADCPK_TX_IDLE,
      ADCPK_TX_DATA,
      ADCPK_TX_END
   } adcpk_tx_e;

endpackage

//--- hdl/adcpk_sender.sv
// byte sender: streams one sample msb first and closes packets with an end token
`timescale 1ns/1ns
`default_nettype none
`include "adcpk_defines.svh"

module adcpk_sender
   import adcpk_pkg::*;
(
   input  wire logic          i_clk,
   input  wire logic          i_rst_n,
   input  wire logic          i_load,
   input  wire adcpk_sample_s i_sample,
   input  wire logic          i_close,
   input  wire logic [23:0]   i_close_dest,
   output logic               o_busy,
   output logic               o_tx_valid,
   output logic [7:0]         o_tx_data,
   output logic               o_tx_end,
   output logic [23:0]        o_tx_dest,
   input  wire logic          i_tx_ready
);

   adcpk_tx_e   state_r;
   logic [31:0] shift_r;
   logic [2:0]  left_r;
   logic        last_r;
   logic [23:0] dest_r;

   // ======
   // byte sequencing; load wins over close when both are offered
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= ADCPK_TX_IDLE;
         shift_r <= 32'h00000000;
         left_r  <= 3'h0;
         last_r  <= 1'b0;
         dest_r  <= 24'h000000;
      end else begin
         case (state_r)
            ADCPK_TX_IDLE: begin
               if (i_load) begin
                  shift_r <= i_sample.data;
                  left_r  <= i_sample.nbytes;
                  last_r  <= i_sample.last;
                  dest_r  <= i_sample.dest;
                  state_r <= ADCPK_TX_DATA;
               end else if (i_close) begin
                  dest_r  <= i_close_dest;
                  state_r <= ADCPK_TX_END;
               end
            end
            ADCPK_TX_DATA: begin
               if (i_tx_ready) begin
                  // most significant byte leaves first
                  shift_r <= {shift_r[23:0], 8'h00};
                  left_r  <= left_r - 3'h1;
                  if (left_r == 3'h1) begin
                     state_r <= last_r ? ADCPK_TX_END : ADCPK_TX_IDLE;
                  end
               end
            end
            ADCPK_TX_END: begin
               if (i_tx_ready) begin
                  state_r <= ADCPK_TX_IDLE;
               end
            end
            default: begin
               state_r <= ADCPK_TX_IDLE;
            end
         endcase
      end
   end

   // handshake outputs decoded from state, data from the shift flops, zero outside the data state
   assign o_busy     = (state_r != ADCPK_TX_IDLE);
   assign o_tx_valid = (state_r != ADCPK_TX_IDLE);
   assign o_tx_end   = (state_r == ADCPK_TX_END);
   assign o_tx_data  = (state_r == ADCPK_TX_DATA) ? shift_r[31:24] : 8'h00;
   assign o_tx_dest  = dest_r;

endmodule
`default_nettype wire

//--- tb/adcpk_top_sva.sv
// assertion checker for the sample packetizer top module ports
`timescale 1ns/1ns
`default_nettype none

module adcpk_top_sva (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_reg_req,
   input  wire logic        i_reg_wr,
   input  wire logic [5:0]  i_reg_addr,
   input  wire logic [31:0] i_reg_wdata,
   input  wire logic        o_reg_ack,
   input  wire logic [31:0] o_reg_rdata,
   input  wire logic        i_sample_pulse,
   input  wire logic        o_conv_start,
   input  wire logic        o_cal_ref_sel,
   input  wire logic        i_conv_done,
   input  wire logic [11:0] i_conv_result,
   input  wire logic        o_tx_valid,
   input  wire logic [7:0]  o_tx_data,
   input  wire logic        o_tx_end,
   input  wire logic        i_tx_ready
);
   logic       en_r;
   logic [1:0] wid_r;
   logic [2:0] cal_r;
   logic       drop_r;
   logic [7:0] res_r;
   logic       gw;
   logic       gr;

   // ======
   // helper logic
   // general register write and read strobes
   assign gw = i_reg_req && i_reg_wr && i_reg_addr[5:2] == 4'h8;
   assign gr = i_reg_req && !i_reg_wr && i_reg_addr[5:2] == 4'h8;

   // shadow of enable and width; calibration count restarts on every enable rise
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         en_r  <= 1'b0;
         wid_r <= 2'h1;
         cal_r <= 3'h0;
      end else begin
         if (gw) begin
            en_r  <= i_reg_wdata[0];
            wid_r <= i_reg_wdata[17:16];
         end
         if (gw && i_reg_wdata[0] && !en_r) begin
            cal_r <= 3'h0;
         end else if (i_conv_done && en_r && cal_r < 3'h6) begin
            cal_r <= cal_r + 3'h1;
         end
      end
   end

   // pessimistic: any finished conversion may drop; only a quiet gap proves a clear
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         drop_r <= 1'b1;
         res_r  <= 8'h00;
      end else begin
         if (i_conv_done) begin
            drop_r <= 1'b1;
            res_r  <= i_conv_result[11:4];
         end else if (gr) begin
            drop_r <= 1'b0;
         end
      end
   end

   // ======
   // properties
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   ack_timing_a:
   assert property (i_reg_req |=> o_reg_ack) else $error("ack missing after request");
   no_stray_ack_a:
   assert property (!i_reg_req |=> !o_reg_ack) else $error("ack without request");
   unmapped_zero_a:
   assert property (i_reg_req && i_reg_addr[5:2] > 4'h8 |=> o_reg_rdata == 32'h00000000)
      else $error("unmapped access returned data");
   route_rsvd_a:
   assert property (i_reg_req && !i_reg_wr && i_reg_addr[5:2] < 4'h8 |=> o_reg_rdata[7:1] == 7'h00)
      else $error("reserved route bits not zero");
   drop_clear_a:
   assert property (gr && !drop_r && !i_conv_done |=> !o_reg_rdata[24])
      else $error("dropped flag survived a read");
   cal_sel_a:
   assert property (gw && i_reg_wdata[1] |-> ##[1:3] o_cal_ref_sel)
      else $error("reference select did not follow bit 1");
   cal_silent_a:
   assert property (i_conv_done && en_r && cal_r < 3'h6 && !o_tx_valid |=> !o_tx_valid)
      else $error("token sent during calibration");
   first_byte_a:
   assert property (i_conv_done && en_r && cal_r == 3'h6 && wid_r != 2'h2 && !o_tx_valid
      |=> o_tx_valid && !o_tx_end && o_tx_data == res_r) else $error("sample head byte wrong");
   rsv_width_a:
   assert property (i_conv_done && en_r && wid_r == 2'h2 && !o_tx_valid |=> !o_tx_valid)
      else $error("reserved width sent data");
   hold_token_a:
   assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data) && $stable(o_tx_end))
      else $error("token changed while stalled");
   start_on_rise_a:
   assert property (o_conv_start |-> $past(i_sample_pulse) && !$past(i_sample_pulse, 2))
      else $error("conversion without pulse rise");
endmodule

bind adcpk_top adcpk_top_sva i_adcpk_top_sva (.i_clk, .i_rst_n,
   .i_reg_req, .i_reg_wr, .i_reg_addr, .i_reg_wdata, .o_reg_ack, .o_reg_rdata, .i_sample_pulse,
   .o_conv_start, .o_cal_ref_sel, .i_conv_done, .i_conv_result, .o_tx_valid, .o_tx_data,
   .o_tx_end, .i_tx_ready);
`default_nettype wire

//--- tb/adcpk_partner.sv
// converter and receiving endpoint model on the far side of the packetizer
`timescale 1ns/1ns
`default_nettype none

module adcpk_partner #(
   parameter int DLY = 3
)(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_stall,
   input  wire logic        i_slow,
   input  wire logic        i_conv_start,
   input  wire logic [2:0]  i_conv_input,
   output logic             o_conv_done,
   output logic [11:0]      o_conv_result,
   input  wire logic        i_tx_valid,
   input  wire logic [7:0]  i_tx_data,
   input  wire logic        i_tx_end,
   input  wire logic [23:0] i_tx_dest,
   output logic             o_tx_ready
);
   logic [32:0] toks[$];
   logic [2:0]  ins[$];
   int          nconv = 0;
   logic [3:0]  cnt_r;
   logic [11:0] val_r;
   logic        slow_r = 1'b0;

   // ======
   // converter: result DLY cycles after start, inverse between results
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r       <= 4'h0;
         o_conv_done <= 1'b0;
         val_r       <= 12'h000;
      end else begin
         o_conv_done <= cnt_r == 4'h1;
         if (o_conv_done) begin
            nconv <= nconv + 1;
         end
         if (i_conv_start) begin
            cnt_r <= DLY[3:0];
            val_r <= 12'hb38 ^ {9'h000, i_conv_input};
            ins.push_back(i_conv_input);
         end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
         end
      end
   end
   assign o_conv_result = o_conv_done ? val_r : ~val_r;

   // ======
   // endpoint: slow mode accepts every other cycle, stall refuses all
   always @(posedge i_clk) begin
      slow_r <= !slow_r;
      if (i_tx_valid && o_tx_ready) begin
         toks.push_back({i_tx_end, i_tx_dest, i_tx_data});
      end
   end
   assign o_tx_ready = !i_stall && (slow_r || !i_slow);
endmodule
`default_nettype wire

//--- tb/tb_adcpk_top.sv
// self-checking testbench for the sample packetizer
`timescale 1ns/1ns
`default_nettype none

module tb_adcpk_top;
   import adcpk_pkg::*;
   localparam logic [23:0] D0 = 24'h13579b;
   localparam logic [23:0] D6 = 24'habcdef;
   logic        clk = 1'b0;
   logic        rst_n, req, wr, spulse, stall, slow;
   logic [5:0]  addr;
   logic [31:0] wdata, rdata, got;
   logic        ack, cstart, csel, cdone, txv, txe, txr;
   logic [2:0]  cinp;
   logic [11:0] cres;
   logic [7:0]  txd;
   logic [23:0] txdest;
   int          fail_count = 0;
   int          comparisons = 0;

   adcpk_top i_adcpk_top (.i_clk(clk), .i_rst_n(rst_n), .i_reg_req(req), .i_reg_wr(wr),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_ack(ack), .o_reg_rdata(rdata),
      .i_sample_pulse(spulse), .o_conv_start(cstart), .o_conv_input(cinp), .o_cal_ref_sel(csel),
      .i_conv_done(cdone), .i_conv_result(cres), .o_tx_valid(txv), .o_tx_data(txd),
      .o_tx_end(txe), .o_tx_dest(txdest), .i_tx_ready(txr));
   adcpk_partner i_p (.i_clk(clk), .i_rst_n(rst_n), .i_stall(stall), .i_slow(slow),
      .i_conv_start(cstart), .i_conv_input(cinp), .o_conv_done(cdone), .o_conv_result(cres),
      .i_tx_valid(txv), .i_tx_data(txd), .i_tx_end(txe), .i_tx_dest(txdest), .o_tx_ready(txr));

   // ======
   // clock
   initial begin
      forever #5 clk = ~clk;
   end

   // ======
   // shared tasks
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [31:0] gen(input logic [1:0] w, input logic [7:0] s, input logic c,
                                       input logic e);
      return {14'h0, w, s, 6'h00, c, e};
   endfunction

   // one register access; request held for the single taking edge
   task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      req   <= 1'b1;
      wr    <= w;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      req   <= 1'b0;
      #1;
      check("ack", {31'h0, ack}, 32'h1);
      got = rdata;
   endtask

   // one bounded wait step; a used-up bound ends the run as a failure
   task automatic tmo(inout int k);
      @(posedge clk);
      #1;
      k++;
      if (k >= 300) begin
         fail_count++;
         final_report();
      end
   endtask

   // bounded wait: conversion finished and, if asked, the sender drained
   task automatic pulse(input bit wait_tx);
      int n;
      int k;
      n = i_p.nconv;
      @(posedge clk);
      spulse <= 1'b1;
      @(posedge clk);
      spulse <= 1'b0;
      k = 0;
      while (i_p.nconv == n || (wait_tx && txv)) tmo(k);
   endtask

   task automatic flush();
      i_p.toks.delete();
      i_p.ins.delete();
   endtask

   // disable, enable, then the six silent calibration pulses
   task automatic run_cfg(input logic [1:0] w, input logic [7:0] s);
      acc(1'b1, 6'h20, gen(w, s, 1'b0, 1'b0));
      acc(1'b1, 6'h20, gen(w, s, 1'b0, 1'b1));
      repeat (6) pulse(1'b1);
      check("cal silent", 32'(i_p.toks.size()), 32'h0);
      flush();
   endtask

   // word is the same for every width; only the byte count changes
   task automatic chk_sample(input logic [1:0] w, input bit last);
      logic [2:0]  inp;
      logic [31:0] word;
      logic [32:0] t;
      int          nb;
      inp  = i_p.ins.pop_front();
      word = {12'hb38 ^ {9'h000, inp}, 20'h00000};
      nb   = (w == 2'h0) ? 1 : (w == 2'h1) ? 2 : 4;
      for (int i = 0; i < nb; i++) begin
         t = i_p.toks.pop_front();
         check("byte", {23'h0, t[32], t[7:0]}, {24'h0, word[31-8*i -: 8]});
         check("dest", {8'h0, t[31:8]}, {8'h0, (inp == 3'h6) ? D6 : D0});
      end
      if (last) begin
         t = i_p.toks.pop_front();
         check("end", {31'h0, t[32]}, 32'h1);
      end
   endtask

   // ======
   // scenarios
   task automatic t_reset();
      acc(1'b0, 6'h20, 32'h0);
      check("gen rst", got, 32'h01010100);
      acc(1'b0, 6'h20, 32'h0);
      check("gen clr", got, 32'h00010100);
      acc(1'b0, 6'h18, 32'h0);
      check("in6 rst", got, 32'h0);
      acc(1'b0, 6'h1c, 32'h0);
      check("in7 rst", got, 32'h0);
      acc(1'b0, 6'h24, 32'h0);
      check("unmapped", got, 32'h0);
   endtask

   task automatic t_routes();
      acc(1'b1, 6'h18, {D6, 8'hff});
      acc(1'b0, 6'h18, 32'h0);
      check("in6 rw", got, {D6, 8'h01});
      acc(1'b1, 6'h00, {D0, 8'h01});
   endtask

   task automatic t_widths();
      for (int w = 0; w < 4; w++) begin
         run_cfg(w[1:0], 8'h01);
         pulse(1'b1);
         if (w == 2) begin
            check("rsv width", 32'(i_p.toks.size()), 32'h0);
         end else begin
            chk_sample(w[1:0], 1'b1);
         end
         flush();
      end
   endtask

   task automatic t_packets();
      slow <= 1'b1;
      run_cfg(2'h1, 8'h02);
      pulse(1'b1);
      pulse(1'b1);
      check("alternate", {29'h0, i_p.ins[0]}, {29'h0, i_p.ins[1] ^ 3'h6});
      chk_sample(2'h1, 1'b0);
      chk_sample(2'h1, 1'b1);
      slow <= 1'b0;
   endtask

   task automatic t_open();
      int k;
      run_cfg(2'h3, 8'h00);
      pulse(1'b1);
      pulse(1'b1);
      chk_sample(2'h3, 1'b0);
      chk_sample(2'h3, 1'b0);
      check("open", 32'(i_p.toks.size()), 32'h0);
      acc(1'b0, 6'h24, 32'h0);
      k = 0;
      while (i_p.toks.size() == 0) tmo(k);
      check("closed", {31'h0, i_p.toks[0][32]}, 32'h1);
      flush();
   endtask

   task automatic t_drop();
      int k;
      run_cfg(2'h3, 8'h01);
      acc(1'b0, 6'h20, 32'h0);
      stall <= 1'b1;
      pulse(1'b0);
      pulse(1'b0);
      acc(1'b0, 6'h20, 32'h0);
      check("drop set", {31'h0, got[24]}, 32'h1);
      stall <= 1'b0;
      k = 0;
      while (txv) tmo(k);
      acc(1'b0, 6'h20, 32'h0);
      check("drop clr", {31'h0, got[24]}, 32'h0);
      chk_sample(2'h3, 1'b1);
      flush();
   endtask

   task automatic t_lock();
      acc(1'b1, 6'h18, 32'h0);
      acc(1'b0, 6'h18, 32'h0);
      check("locked", got, {D6, 8'h01});
      acc(1'b1, 6'h20, gen(2'h3, 8'h01, 1'b1, 1'b1));
      acc(1'b0, 6'h20, 32'h0);
      check("cal sel", {31'h0, csel}, 32'h1);
      pulse(1'b1);
      flush();
   endtask

   // ======
   // main sequence
   initial begin
      rst_n  = 1'b0;
      req    = 1'b0;
      wr     = 1'b0;
      addr   = 6'h00;
      wdata  = 32'h0;
      spulse = 1'b0;
      stall  = 1'b0;
      slow   = 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_routes();
      t_widths();
      t_packets();
      t_open();
      t_drop();
      t_lock();
      final_report();
   end
endmodule
`default_nettype wire
